// ### rtl/ecgtr_regs.sv
// Threshold and channel data register bank with AXI4-Lite slave
// How it works
// - Flag code above max minus setting times 64
// - Overrange setting zero disables the flag
// - Flag code below min plus setting times 64
// - Underrange setting zero disables the flag
// - Ac lead-off when output reaches twice upper
// - Ac lead-off when output at most twice lower
// - Three edge thresholds, channel three top byte
// - Edge zero means half amplitude threshold
// - Level thresholds are signed LSB counts
// - Channel readback top byte carries register index
// - Channel value left justified at every rate
// - Electrode and analog lead values unsigned
// - Digital lead values signed, double LSB
// - Sixteen bits fastest rate, else twenty-four
// - Fast frame word sends upper sixteen only
module ecgtr_regs
(
   input  wire logic        mclk,          // Clock, 250 MHz
   input  wire logic        rst_b,         // Async reset, active low
   input  wire logic [7:0]  s_axi_awaddr,  // Write address
   input  wire logic        s_axi_awvalid, // Write address valid
   output logic             s_axi_awready, // Write address ready
   input  wire logic [31:0] s_axi_wdata,   // Write data
   input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
   input  wire logic        s_axi_wvalid,  // Write data valid
   output logic             s_axi_wready,  // Write data ready
   output logic [1:0]       s_axi_bresp,   // Write response
   output logic             s_axi_bvalid,  // Write response valid
   input  wire logic        s_axi_bready,  // Write response ready
   input  wire logic [7:0]  s_axi_araddr,  // Read address
   input  wire logic        s_axi_arvalid, // Read address valid
   output logic             s_axi_arready, // Read address ready
   output logic [31:0]      s_axi_rdata,   // Read data
   output logic [1:0]       s_axi_rresp,   // Read response
   output logic             s_axi_rvalid,  // Read data valid
   input  wire logic        s_axi_rready,  // Read data ready
   input  wire logic        sample_valid,  // New sample strobe
   input  wire logic [1:0]  sample_chan,   // Sample channel 0..2
   input  wire logic [23:0] sample_data,   // Raw sample code
   input  wire logic [1:0]  data_rate,     // Output data rate select
   input  wire logic        digital_lead,  // Digital lead mode
   input  wire logic        ac_leadoff_mode, // Ac lead-off on
   input  wire logic [7:0]  pulse_amplitude_threshold, // Amplitude
   output logic [2:0]       over_err,      // Overrange per channel
   output logic [2:0]       under_err,     // Underrange per channel
   output logic [2:0]       leadoff,       // Lead-off per channel
   output logic [23:0]      edge_limit,    // Edge limits, 8 bits each
   output logic [47:0]      level_limit,   // Level limits, 16 each
   output logic [31:0]      frame_word,    // Frame data word
   output logic             frame_short,   // Only upper 16 bits valid
   output logic             frame_valid    // Frame word strobe
);
   import ecgtr_pkg::*;
   logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic        frame_short_reg, frame_valid_reg, rd_ok, wr_go, wr_ok, fast;
   logic        rc_over, rc_under, rc_leadoff;
   logic [1:0]  bresp_reg, rresp_reg;
   logic [31:0] rdata_reg, rd_next, frame_word_reg;
   logic [5:0]  aw_idx_q, rd_idx_q;
   logic [23:0] wdata_q, edge_limit_reg, fmt_value;
   logic [2:0]  wstrb_q, over_reg, under_reg, leadoff_reg;
   logic [23:0] upper_reg, lower_reg, pace_edge_reg, pace_level_reg;
   logic [23:0] ch_res_reg [0:NCH-1];
   logic [47:0] level_limit_reg;
   //------------------------------------------------------------
   // Write address and data capture, either order
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         awready_reg <= 1'b1;
         aw_idx_q    <= 6'h00;
      end
      else if (s_axi_awvalid && awready_reg)
      begin
         awready_reg <= 1'b0;
         aw_idx_q    <= s_axi_awaddr[IDX_HI:IDX_LSB];
      end
      else if (bvalid_reg && s_axi_bready)
         awready_reg <= 1'b1;
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         wready_reg <= 1'b1;
         wdata_q    <= 24'h000000;
         wstrb_q    <= 3'h0;
      end
      else if (s_axi_wvalid && wready_reg)
      begin
         wready_reg <= 1'b0;
         wdata_q    <= s_axi_wdata[DATA_W-1:0];
         wstrb_q    <= s_axi_wstrb[2:0];
      end
      else if (bvalid_reg && s_axi_bready)
         wready_reg <= 1'b1;
   // Both halves held and no response pending: commit once
   assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_ok = (aw_idx_q == IDX_UPPER) || (aw_idx_q == IDX_LOWER)
               || (aw_idx_q == IDX_EDGE)  || (aw_idx_q == IDX_LEVEL);
   // Read-only and unmapped writes are dropped with an error
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   //------------------------------------------------------------
   // Writable threshold registers
   //------------------------------------------------------------
   // Reserved top nibble of the limit registers is forced to zero
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         upper_reg      <= RST_UPPER;
         lower_reg      <= RST_LOWER;
         pace_edge_reg  <= RST_EDGE;
         pace_level_reg <= RST_LEVEL;
      end
      else if (wr_go)
      begin
         case (aw_idx_q)
            IDX_UPPER: upper_reg <= ecgtr_wr(upper_reg, wdata_q,
                                             wstrb_q, LIM_WMASK);
            IDX_LOWER: lower_reg <= ecgtr_wr(lower_reg, wdata_q,
                                             wstrb_q, LIM_WMASK);
            IDX_EDGE:  pace_edge_reg <= ecgtr_wr(pace_edge_reg, wdata_q,
                                                 wstrb_q, PACE_WMASK);
            IDX_LEVEL: pace_level_reg <= ecgtr_wr(pace_level_reg, wdata_q,
                                                  wstrb_q, PACE_WMASK);
            default: ;
         endcase
      end
   //------------------------------------------------------------
   // Read path, one cycle after the address is taken
   //------------------------------------------------------------
   always_comb
   begin
      rd_next = 32'h00000000;
      rd_ok   = 1'b1;
      case (s_axi_araddr[IDX_HI:IDX_LSB])
         IDX_UPPER: rd_next = {8'h00, upper_reg};
         IDX_LOWER: rd_next = {8'h00, lower_reg};
         IDX_EDGE:  rd_next = {8'h00, pace_edge_reg};
         IDX_LEVEL: rd_next = {8'h00, pace_level_reg};
         IDX_CH1:   rd_next = {2'b00, IDX_CH1, ch_res_reg[0]};
         IDX_CH2:   rd_next = {2'b00, IDX_CH2, ch_res_reg[1]};
         IDX_CH3:   rd_next = {2'b00, IDX_CH3, ch_res_reg[2]};
         default:   rd_ok   = 1'b0;
      endcase
   end
   // Register reads always return the full 32-bit word
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= RESP_OKAY;
         rd_idx_q    <= 6'h00;
      end
      else if (s_axi_arvalid && arready_reg)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_next;
         rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         rd_idx_q    <= s_axi_araddr[IDX_HI:IDX_LSB];
      end
      else if (rvalid_reg && s_axi_rready)
      begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   //------------------------------------------------------------
   // Sample checking and formatting
   //------------------------------------------------------------
   assign fast = (data_rate == RATE_FAST);
   ecgtr_range_check u_range (
      .code      (sample_data),
      .over_ofs  (upper_reg[OFS_HI:OFS_LO]),
      .under_ofs (lower_reg[OFS_HI:OFS_LO]),
      .upper     (upper_reg[THR_HI:0]),
      .lower     (lower_reg[THR_HI:0]),
      .ac_mode   (ac_leadoff_mode),
      .over      (rc_over),
      .under     (rc_under),
      .leadoff   (rc_leadoff)
   );
   ecgtr_chan_format u_fmt (
      .raw     (sample_data),
      .fast    (fast),
      .digital (digital_lead),
      .value   (fmt_value)
   );
   // Flags follow the latest sample of each channel; sample_chan 3 ignored
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         for (int c = 0; c < NCH; c++)
            ch_res_reg[c] <= 24'h000000;
         over_reg    <= 3'h0;
         under_reg   <= 3'h0;
         leadoff_reg <= 3'h0;
      end
      else if (sample_valid)
      begin
         for (int c = 0; c < NCH; c++)
            if (sample_chan == 2'(c))
            begin
               ch_res_reg[c]  <= fmt_value;
               over_reg[c]    <= rc_over;
               under_reg[c]   <= rc_under;
               leadoff_reg[c] <= rc_leadoff;
            end
      end
   // Frame word; the fast rate only has room for the upper half
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         frame_word_reg  <= 32'h00000000;
         frame_short_reg <= 1'b0;
         frame_valid_reg <= 1'b0;
      end
      else
      begin
         frame_valid_reg <= sample_valid && (sample_chan < 2'(NCH));
         if (sample_valid)
         begin
            frame_short_reg <= fast;
            frame_word_reg  <= fast
               ? {2'b00, IDX_CH1 + 6'(sample_chan), fmt_value[23:16],
                  16'h0000}
               : {2'b00, IDX_CH1 + 6'(sample_chan), fmt_value};
         end
      end
   //------------------------------------------------------------
   // Pace threshold decode
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         edge_limit_reg  <= 24'h000000;
         level_limit_reg <= 48'h000000000000;
      end
      else
         for (int c = 0; c < NCH; c++)
         begin
            edge_limit_reg[c*BYTE_W +: BYTE_W] <= ecgtr_edge_eff(
               pace_edge_reg[c*BYTE_W +: BYTE_W],
               pulse_amplitude_threshold);
            level_limit_reg[c*FAST_W +: FAST_W] <= ecgtr_sext(
               pace_level_reg[c*BYTE_W +: BYTE_W]);
         end
   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign over_err      = over_reg;
   assign under_err     = under_reg;
   assign leadoff       = leadoff_reg;
   assign edge_limit    = edge_limit_reg;
   assign level_limit   = level_limit_reg;
   assign frame_word    = frame_word_reg;
   assign frame_short   = frame_short_reg;
   assign frame_valid   = frame_valid_reg;
   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_ch0; sample_valid && (sample_chan == 2'h0); endsequence
   sequence s_ar_taken; s_axi_arvalid && arready_reg; endsequence

   a_over_flag: assert property (s_ch0 ##0 (sample_data > ADC_MAX
      - ecgtr_ofs_scale(upper_reg[OFS_HI:OFS_LO])) |=> over_reg[0])
      else $error("overrange not flagged");
   a_over_off: assert property (s_ch0 ##0
      (upper_reg[OFS_HI:OFS_LO] == 4'h0) |=> !over_reg[0])
      else $error("overrange flagged while disabled");
   a_under_flag: assert property (s_ch0 ##0 (sample_data < ADC_MIN
      + ecgtr_ofs_scale(lower_reg[OFS_HI:OFS_LO])) |=> under_reg[0])
      else $error("underrange not flagged");
   a_under_off: assert property (s_ch0 ##0
      (lower_reg[OFS_HI:OFS_LO] == 4'h0) |=> !under_reg[0])
      else $error("underrange flagged while disabled");
   a_loff_upper: assert property (s_ch0 ##0 ac_leadoff_mode ##0
      ({1'b0, sample_data[23:8]} >= {upper_reg[15:0], 1'b0})
      |=> leadoff_reg[0])
      else $error("upper lead-off missed");
   a_loff_lower: assert property (s_ch0 ##0 ac_leadoff_mode ##0
      ({1'b0, sample_data[23:8]} <= {lower_reg[15:0], 1'b0})
      |=> leadoff_reg[0])
      else $error("lower lead-off missed");
   a_edge_half: assert property ((pace_edge_reg[7:0] == 8'h00)
      ##1 ((pace_edge_reg[7:0] == 8'h00)
      && $stable(pulse_amplitude_threshold))
      |-> (edge_limit_reg[7:0] == (pulse_amplitude_threshold >> 1)))
      else $error("zero edge threshold not half amplitude");
   a_level_neg: assert property ((pace_level_reg[15:8] == 8'hff)
      |=> (level_limit_reg[31:16] == 16'hffff))
      else $error("level threshold not sign extended");
   a_chan_tag: assert property (s_ar_taken ##0
      (s_axi_araddr[IDX_HI:IDX_LSB] == IDX_CH2)
      |=> s_axi_rvalid && (s_axi_rdata[31:24] == {2'b00, IDX_CH2}))
      else $error("channel readback address byte wrong");
   a_fast_pad: assert property (s_ch0 ##0 fast
      |=> (ch_res_reg[0][PAD_W-1:0] == 8'h00))
      else $error("fast sample not left justified");
   a_digital_mid: assert property (s_ch0 ##0 digital_lead && !fast
      && (sample_data == 24'h800000) |=> (ch_res_reg[0] == 24'h000000))
      else $error("digital lead mid code not zero");
   a_frame_half: assert property (s_ch0 ##0 fast
      |=> frame_short_reg && (frame_word_reg[15:0] == 16'h0000))
      else $error("fast frame word not halved");
   a_resv_zero: assert property (s_axi_rvalid && (rd_idx_q == IDX_UPPER)
      |-> (s_axi_rdata[31:20] == 12'h000))
      else $error("reserved bits read nonzero");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before accept");
   a_wr_resp: assert property (wr_go |=> s_axi_bvalid ##0 !wr_go)
      else $error("write response missing");
endmodule : ecgtr_regs

// ### rtl/ecgtr_pkg.sv
// Constants, register map and helper functions of the threshold register bank
package ecgtr_pkg;

   //------------------------------------------------------------
   // Widths and channel count
   //------------------------------------------------------------
   localparam int DATA_W  = 24;
   localparam int FAST_W  = 16;
   localparam int PAD_W   = 8;
   localparam int BYTE_W  = 8;
   localparam int NCH     = 3;
   localparam int IDX_LSB = 2;
   localparam int IDX_HI  = 7;

   //------------------------------------------------------------
   // Register indices; byte address is four times the index
   //------------------------------------------------------------
   localparam logic [5:0] IDX_UPPER = 6'h0c;
   localparam logic [5:0] IDX_LOWER = 6'h0d;
   localparam logic [5:0] IDX_EDGE  = 6'h0e;
   localparam logic [5:0] IDX_LEVEL = 6'h0f;
   localparam logic [5:0] IDX_CH1   = 6'h11;
   localparam logic [5:0] IDX_CH2   = 6'h12;
   localparam logic [5:0] IDX_CH3   = 6'h13;

   //------------------------------------------------------------
   // Reset values, write masks and field positions
   //------------------------------------------------------------
   localparam logic [23:0] RST_UPPER  = 24'h00ffff;
   localparam logic [23:0] RST_LOWER  = 24'h000000;
   localparam logic [23:0] RST_EDGE   = 24'h000001;
   localparam logic [23:0] RST_LEVEL  = 24'h000000;
   localparam logic [23:0] LIM_WMASK  = 24'h0fffff;
   localparam logic [23:0] PACE_WMASK = 24'hffffff;
   localparam int OFS_HI = 19;
   localparam int OFS_LO = 16;
   localparam int THR_HI = 15;
   localparam int OFS_SH = 6;

   //------------------------------------------------------------
   // Codes
   //------------------------------------------------------------
   localparam logic [23:0] ADC_MAX     = 24'hffffff;
   localparam logic [23:0] ADC_MIN     = 24'h000000;
   localparam logic [1:0]  RATE_FAST   = 2'h2;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Range setting scaled to ADC codes (times 64)
   function automatic logic [23:0] ecgtr_ofs_scale(input logic [3:0] ofs);
      ecgtr_ofs_scale = 24'(ofs) << OFS_SH;
   endfunction : ecgtr_ofs_scale

   // Edge threshold: zero selects half the amplitude threshold
   function automatic logic [7:0] ecgtr_edge_eff(input logic [7:0] n,
                                                 input logic [7:0] amp);
      ecgtr_edge_eff = (n == 8'h00) ? (amp >> 1) : n;
   endfunction : ecgtr_edge_eff

   // Signed level threshold widened to the 16-bit scale
   function automatic logic [15:0] ecgtr_sext(input logic [7:0] b);
      ecgtr_sext = {{BYTE_W{b[BYTE_W-1]}}, b};
   endfunction : ecgtr_sext

   // Byte-lane merge of a write into a 24-bit register
   function automatic logic [23:0] ecgtr_wr(input logic [23:0] old,
                                            input logic [23:0] dat,
                                            input logic [2:0]  strb,
                                            input logic [23:0] mask);
      logic [23:0] v;
      v = old;
      for (int i = 0; i < 3; i++)
         if (strb[i])
            v[i*BYTE_W +: BYTE_W] = dat[i*BYTE_W +: BYTE_W];
      ecgtr_wr = v & mask;
   endfunction : ecgtr_wr

endpackage : ecgtr_pkg

// ### rtl/ecgtr_range_check.sv
// ADC range and ac lead-off comparators for one sample
module ecgtr_range_check
   import ecgtr_pkg::*;
(
   input  wire logic [23:0] code,      // Raw unsigned ADC code
   input  wire logic [3:0]  over_ofs,  // Overrange setting
   input  wire logic [3:0]  under_ofs, // Underrange setting
   input  wire logic [15:0] upper,     // Lead-off upper threshold
   input  wire logic [15:0] lower,     // Lead-off lower threshold
   input  wire logic        ac_mode,   // Ac lead-off detection on
   output logic             over,      // Above overrange limit
   output logic             under,     // Below underrange limit
   output logic             leadoff    // Ac lead-off seen
);

   logic [23:0] over_lim;
   logic [23:0] under_lim;
   logic [16:0] amp;

   //------------------------------------------------------------
   // Limits
   //------------------------------------------------------------
   // Setting zero gives the end code, so no code can pass it
   assign over_lim  = ADC_MAX - ecgtr_ofs_scale(over_ofs);
   assign under_lim = ADC_MIN + ecgtr_ofs_scale(under_ofs);
   assign over      = code > over_lim;
   assign under     = code < under_lim;

   // Thresholds count two 16-bit LSBs, hence the shift by one
   assign amp     = {1'b0, code[DATA_W-1 -: FAST_W]};
   assign leadoff = ac_mode & ((amp >= {upper, 1'b0})
                            | (amp <= {lower, 1'b0}));

endmodule : ecgtr_range_check

// ### rtl/ecgtr_chan_format.sv
// Justifies and encodes one channel sample for readback
module ecgtr_chan_format
   import ecgtr_pkg::*;
(
   input  wire logic [23:0] raw,     // Right-justified converter code
   input  wire logic        fast,    // Fastest rate, 16 valid bits
   input  wire logic        digital, // Digital lead mode
   output logic [23:0]      value    // Left-justified channel value
);

   logic [23:0] just;

   //------------------------------------------------------------
   // Justify, then encode
   //------------------------------------------------------------
   // Fast rate keeps 16 bits, slower rates keep all 24
   assign just = fast ? {raw[FAST_W-1:0], {PAD_W{1'b0}}}
                      : raw;
   // Electrode and analog lead stay unsigned; digital lead is signed
   // around mid code, which halves resolution per volt
   assign value = digital ? {~just[DATA_W-1], just[DATA_W-2:0]}
                          : just;

endmodule : ecgtr_chan_format

// ### tb/ecgtr_host_model.sv
// Host model: AXI4-Lite master that reaches the register bank
module ecgtr_host_model
(
   input  wire logic        mclk,                  // Clock
   output logic [7:0]       s_axi_awaddr  = 8'h00, // Write address
   output logic             s_axi_awvalid = 1'b0,  // Write address valid
   input  wire logic        s_axi_awready,         // Write address ready
   output logic [31:0]      s_axi_wdata   = '0,    // Write data
   output logic [3:0]       s_axi_wstrb   = 4'hf,  // Byte strobes
   output logic             s_axi_wvalid  = 1'b0,  // Write data valid
   input  wire logic        s_axi_wready,          // Write data ready
   input  wire logic [1:0]  s_axi_bresp,           // Write response
   input  wire logic        s_axi_bvalid,          // Response valid
   output logic             s_axi_bready  = 1'b0,  // Response ready
   output logic [7:0]       s_axi_araddr  = 8'h00, // Read address
   output logic             s_axi_arvalid = 1'b0,  // Read address valid
   input  wire logic        s_axi_arready,         // Read address ready
   input  wire logic [31:0] s_axi_rdata,           // Read data
   input  wire logic [1:0]  s_axi_rresp,           // Read response
   input  wire logic        s_axi_rvalid,          // Read data valid
   output logic             s_axi_rready  = 1'b0   // Read data ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Write one word; a taken channel shows inverted payload, so a slave
   // that samples late cannot pass on stale data by luck
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] resp);
      @(posedge mclk);
      {s_axi_awvalid, s_axi_awaddr} <= {1'b1, a};
      {s_axi_wvalid, s_axi_wdata} <= {1'b1, d};
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
         if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end
      while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   // Read one word; rready waits high for the answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] resp);
      @(posedge mclk);
      {s_axi_arvalid, s_axi_araddr, s_axi_rready} <= {1'b1, a, 1'b1};
      do
      begin
         @(posedge mclk);
         if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      end
      while (s_axi_rvalid !== 1'b1);
      {d, resp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : ecgtr_host_model

// ### tb/ecg_threshold_and_data_regs_tb_top.sv
// Testbench top: register bank scenarios through the host model
module ecg_threshold_and_data_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ecgtr_pkg::*;
   logic mclk, rst_b = 1'b0, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, frame_short;
   logic frame_valid, sample_valid = 1'b0, digital_lead = 1'b0;
   logic ac_leadoff_mode = 1'b0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [1:0]  sample_chan = 2'h0, data_rate = 2'h0;
   logic [2:0]  over_err, under_err, leadoff;
   logic [3:0]  s_axi_wstrb;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [7:0]  pulse_amplitude_threshold = 8'h00;
   logic [23:0] sample_data = '0, edge_limit;
   logic [31:0] s_axi_wdata, s_axi_rdata, frame_word, rdat;
   logic [47:0] level_limit;
   int          miscompares = 0;
   int          compares = 0;

   ecgtr_host_model host (.*);
   ecgtr_regs       uut  (.*);

   // Free-running 250 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic chk(input string what, input logic [47:0] exp,
                      input logic [47:0] got);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   // One sample strobe; returns once its results have landed
   task automatic smp(input logic [1:0] c, input logic [23:0] d);
      @(posedge mclk);
      {sample_valid, sample_chan, sample_data} <= {1'b1, c, d};
      @(posedge mclk);
      sample_valid <= 1'b0;
      #1;
   endtask : smp

   // Reset values, then refused accesses
   task automatic t_reset;
      logic [7:0]  a [5] = '{8'h30, 8'h34, 8'h38, 8'h3c, 8'h44};
      logic [31:0] v [5] = '{32'hffff, 32'h0, 32'h1, 32'h0, 32'h11000000};
      for (int i = 0; i < 5; i++)
      begin
         host.rd(a[i], rdat, resp);
         chk("reset value", v[i], rdat);
      end
      host.rd(8'h40, rdat, resp);
      chk("unmapped read", {RESP_SLVERR, 32'h0}, {resp, rdat});
      host.wr(8'h44, 32'h1, resp);
      chk("read-only write", RESP_SLVERR, resp);
   endtask : t_reset

   // Zero settings disable range flags; each step moves a limit by 64
   task automatic t_range;
      smp(2'h0, 24'hffffff);
      chk("over off", 3'h0, over_err);
      smp(2'h1, 24'h000000);
      chk("under off", 3'h0, under_err);
      host.wr(8'h30, 32'hfff1ffff, resp);
      host.rd(8'h30, rdat, resp);
      chk("reserved bits", 32'h0001ffff, rdat);
      host.wr(8'h34, 32'h00010010, resp);
      smp(2'h0, 24'hffffc0);
      chk("over", 3'h1, over_err);
      smp(2'h0, 24'hffffbf);
      chk("over at limit", 3'h0, over_err);
      smp(2'h1, 24'h00003f);
      chk("under", 3'h2, under_err);
      smp(2'h1, 24'h000040);
      chk("under at limit", 3'h0, under_err);
   endtask : t_range

   // Lead-off against twice the thresholds, both boundaries
   task automatic t_leadoff;
      @(posedge mclk);
      ac_leadoff_mode <= 1'b1;
      smp(2'h2, 24'h002000);
      chk("leadoff lower", 3'h4, leadoff);
      smp(2'h2, 24'h002100);
      chk("leadoff none", 3'h0, leadoff);
      host.wr(8'h30, 32'h00000011, resp);
      smp(2'h2, 24'h002100);
      chk("leadoff none", 3'h0, leadoff);
      smp(2'h2, 24'h002200);
      chk("leadoff upper", 3'h4, leadoff);
   endtask : t_leadoff

   // Edge zero falls back to half amplitude; level bytes are signed
   task automatic t_pace;
      @(posedge mclk);
      pulse_amplitude_threshold <= 8'h0b;
      host.wr(8'h38, 32'h00000300, resp);
      host.wr(8'h3c, 32'h0001ff80, resp);
      repeat (2) @(posedge mclk);
      #1;
      chk("edge limits", 24'h050305, edge_limit);
      chk("level limits", 48'h0001ffffff80, level_limit);
   endtask : t_pace

   // Fast rate framing, then digital and electrode encodings
   task automatic t_data;
      @(posedge mclk);
      data_rate <= RATE_FAST;
      smp(2'h0, 24'h001234);
      chk("frame", {2'h3, 32'h11120000},
          {frame_valid, frame_short, frame_word});
      host.rd(8'h44, rdat, resp);
      chk("fast result", 32'h11123400, rdat);
      @(posedge mclk);
      {data_rate, digital_lead} <= {2'h0, 1'b1};
      smp(2'h0, 24'h800000);
      host.rd(8'h44, rdat, resp);
      chk("digital mid", 32'h11000000, rdat);
      smp(2'h2, 24'h800001);
      host.rd(8'h4c, rdat, resp);
      chk("digital result", 32'h13000001, rdat);
      @(posedge mclk);
      digital_lead <= 1'b0;
      smp(2'h1, 24'h800001);
      host.rd(8'h48, rdat, resp);
      chk("electrode result", 32'h12800001, rdat);
   endtask : t_data

   initial
   begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_range();
      t_leadoff();
      t_pace();
      t_data();
      end_of_test();
   end

   // Watchdog: the run needs well under a thousand cycles
   initial
   begin
      #20us;
      miscompares++;
      end_of_test();
   end
endmodule : ecg_threshold_and_data_regs_tb_top
